//--- fpc_pkg.sv
/*
 * Shared constants and carrier types for the flash program control block.
 * Assumes a 32-bit classic Wishbone bus; each register sits in one aligned word.
 */
package fpc_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [31:0] IDX_MODE_ENTRY  = 32'h008007E2;
    localparam logic [31:0] IDX_UNLOCK      = 32'h008007E3;
    localparam logic [31:0] IDX_ERASE_MARG  = 32'h008007E4;
    localparam logic [31:0] IDX_ABORT       = 32'h008007E5;
    localparam logic [31:0] IDX_LARGE_BANK  = 32'h008007E8;
    localparam logic [31:0] IDX_SMALL_BANK0 = 32'h008007F0;
    localparam logic [31:0] IDX_SMALL_BANK1 = 32'h008007F2;
    localparam logic [31:0] IDX_OP_STATUS   = 32'h008007F8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int POS_PE_MODE   = 4;
    localparam int POS_EMU_MODE  = 0;
    localparam int POS_LOCK_OVR  = 0;
    localparam int POS_DEEP_ERS  = 0;
    localparam int POS_ABORT     = 0;
    localparam int POS_LB_EN     = 15;
    localparam int POS_LB_ADDR_L = 1;
    localparam int POS_SB_EN     = 15;
    localparam int POS_SB_ADDR_L = 0;
    localparam int POS_ST_BUSY   = 7;
    localparam int POS_ST_ERASE  = 5;
    localparam int POS_ST_VERIFY = 4;
    localparam int POS_ST_RETRY  = 3;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  STATUS_INIT     = 8'h80;
    localparam logic [15:0] CMD_READ_STATUS = 16'h7070;
    localparam logic [31:0] EI_VEC_FLASH    = 32'h00000080;
    localparam logic [31:0] EI_VEC_RAM      = 32'h00804000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       enable;
        logic [6:0] addr;
    } fpc_large_bank_s;

    typedef struct packed {
        logic       enable;
        logic [7:0] addr;
    } fpc_small_bank_s;

endpackage : fpc_pkg

//--- fpc_flash_ctrl.sv
/*
 * Flash program control registers: mode entry, unlock, erase margin, abort,
 * in-array status and virtual flash bank selection, on a classic Wishbone slave.
 * Assumes the flash array runs on ref_clk and reports its events as one-cycle
 * pulses; the flash-protect pin is asynchronous and is synchronised here.
 */
// Overview of operation
// - Program done with a zero where data needed one sets verify error.
// - Retries exhausted without programming sets the retry error.
// - Read-status command code on any flash write selects status for reads.
// - Program/erase mode exists only while the mode-entry bit is one.
// - Mode-entry sets only on write 0 then write 1 with protect pin high.
// - Mode-entry clears on write 0, reset, or protect pin falling.
// - Interrupt vector is flash 0x80 with mode off, RAM base with it on.
// - Emulation mode bit may be set only while mode-entry is zero.
// - Unlock bit set overrides per-block lock protection.
// - Unlock sets only on write 0 then write 1 while mode-entry is one.
// - Unlock clears on reset, write 0, protect pin low, mode-entry clear.
// - Erase-margin bit requests deeper erase from the array.
// - Abort bit aborts the operation and reinitialises status to 0x80.
// - Abort bit acts only while mode-entry is one; ignored otherwise.
// - Large-bank enable settable only in emulation mode; enables substitution.
// - Large-bank address field holds A13-A19 of an 8 KB bank start.
// - Each small-bank enable settable only in emulation mode.
// - Small-bank address field holds A12-A19 of a 4 KB bank start.
// - Busy flag reads 0 while operating, 1 once terminated.
module fpc_flash_ctrl #(
    parameter int NUM_SMALL = 2
) (
    input  wire logic                   ref_clk,
    input  wire logic                   nrst,
    // Wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [31:0]            wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // Pin and flash array
    input  wire logic                   flash_protect_pin,
    input  wire logic                   array_busy,
    input  wire logic                   prog_done,
    input  wire logic [15:0]            prog_wdata,
    input  wire logic [15:0]            prog_rdata,
    input  wire logic                   retry_exhausted,
    input  wire logic                   erase_fail,
    input  wire logic                   flash_cmd_we,
    input  wire logic [15:0]            flash_cmd_data,
    // Control outputs
    output logic                        pe_mode,
    output logic                        emulation_mode,
    output logic                        lock_override,
    output logic                        deep_erase,
    output logic                        flash_abort,
    output logic                        status_read_sel,
    output logic      [7:0]             array_op_status,
    output logic      [31:0]            ei_vector_addr,
    output fpc_pkg::fpc_large_bank_s    large_bank,
    output fpc_pkg::fpc_small_bank_s    small_bank [NUM_SMALL]
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (NUM_SMALL != 2) begin : g_bad_small
        $error("NUM_SMALL must be 2: two small-bank registers are mapped");
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic        req;
    logic        wr_fire;
    logic        hit_mode;
    logic        hit_unlock;
    logic        hit_marg;
    logic        hit_abort;
    logic        hit_lb;
    logic        hit_sb [NUM_SMALL];
    logic        hit_stat;
    logic [31:0] next_dat;

    assign req        = wb_cyc_i & wb_stb_i;
    assign wr_fire    = req & wb_we_i & wb_ack_o;
    assign hit_mode   = wb_adr_i[31:2] == fpc_pkg::IDX_MODE_ENTRY[29:0];
    assign hit_unlock = wb_adr_i[31:2] == fpc_pkg::IDX_UNLOCK[29:0];
    assign hit_marg   = wb_adr_i[31:2] == fpc_pkg::IDX_ERASE_MARG[29:0];
    assign hit_abort  = wb_adr_i[31:2] == fpc_pkg::IDX_ABORT[29:0];
    assign hit_lb     = wb_adr_i[31:2] == fpc_pkg::IDX_LARGE_BANK[29:0];
    assign hit_sb[0]  = wb_adr_i[31:2] == fpc_pkg::IDX_SMALL_BANK0[29:0];
    assign hit_sb[1]  = wb_adr_i[31:2] == fpc_pkg::IDX_SMALL_BANK1[29:0];
    assign hit_stat   = wb_adr_i[31:2] == fpc_pkg::IDX_OP_STATUS[29:0];

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    // ------------------------------------------------------------------
    // Protect pin synchroniser
    // ------------------------------------------------------------------
    logic [2:0] fp_sync;
    logic       fp_lvl;
    logic       fp_fall;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fp_sync <= 3'h0;
        end else begin
            fp_sync <= {fp_sync[1:0], flash_protect_pin};
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fp_lvl <= 1'b0;
        end else if (fp_sync[1] == fp_sync[2]) begin
            fp_lvl <= fp_sync[2];
        end
    end

    assign fp_fall = fp_lvl & (fp_sync[1] == fp_sync[2]) & ~fp_sync[2];

    // ------------------------------------------------------------------
    // Mode entry and emulation mode
    // ------------------------------------------------------------------
    logic wr_mode;
    logic mode_bit_wd;
    logic mode_armed;

    assign wr_mode     = wr_fire & hit_mode & wb_sel_i[0];
    assign mode_bit_wd = wb_dat_i[fpc_pkg::POS_PE_MODE];

    // Arm after a write of 0; any other bus write breaks the sequence
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_armed <= 1'b0;
        end else if (wr_fire) begin
            mode_armed <= wr_mode & ~mode_bit_wd;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pe_mode <= 1'b0;
        end else if (fp_fall) begin
            pe_mode <= 1'b0;
        end else if (wr_mode) begin
            // Two-write entry, a repeated 1 keeps it; level gates the mode
            pe_mode <= mode_bit_wd & (pe_mode | (mode_armed & fp_lvl));
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            emulation_mode <= 1'b0;
        end else if (wr_mode) begin
            emulation_mode <= wb_dat_i[fpc_pkg::POS_EMU_MODE] & (~pe_mode | emulation_mode);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ei_vector_addr <= fpc_pkg::EI_VEC_FLASH;
        end else begin
            ei_vector_addr <= pe_mode ? fpc_pkg::EI_VEC_RAM : fpc_pkg::EI_VEC_FLASH;
        end
    end

    // ------------------------------------------------------------------
    // Unlock, erase margin, abort
    // ------------------------------------------------------------------
    logic wr_unlock;
    logic unlock_armed;
    logic wr_abort;

    assign wr_unlock = wr_fire & hit_unlock & wb_sel_i[0];
    assign wr_abort  = wr_fire & hit_abort & wb_sel_i[0];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            unlock_armed <= 1'b0;
        end else if (wr_fire) begin
            unlock_armed <= wr_unlock & ~wb_dat_i[fpc_pkg::POS_LOCK_OVR];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lock_override <= 1'b0;
        end else if (!fp_lvl || !pe_mode) begin
            lock_override <= 1'b0;
        end else if (wr_unlock) begin
            // Two-write unlock; level drives lock bypass
            lock_override <= wb_dat_i[fpc_pkg::POS_LOCK_OVR] & (lock_override | unlock_armed);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            deep_erase <= 1'b0;
        end else if (wr_fire && hit_marg && wb_sel_i[0]) begin
            deep_erase <= wb_dat_i[fpc_pkg::POS_DEEP_ERS];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flash_abort <= 1'b0;
        end else if (!pe_mode) begin
            flash_abort <= 1'b0;
        end else if (wr_abort) begin
            flash_abort <= wb_dat_i[fpc_pkg::POS_ABORT];
        end
    end

    // ------------------------------------------------------------------
    // In-array status
    // ------------------------------------------------------------------
    logic verify_miss;

    assign verify_miss = |(prog_wdata & ~prog_rdata);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            array_op_status <= fpc_pkg::STATUS_INIT;
        end else begin
            array_op_status[fpc_pkg::POS_ST_BUSY] <= ~array_busy;
            // Abort reinitialises errors; new events win
            if (flash_abort) begin
                array_op_status[fpc_pkg::POS_ST_ERASE]  <= erase_fail;
                array_op_status[fpc_pkg::POS_ST_VERIFY] <= prog_done & verify_miss;
                array_op_status[fpc_pkg::POS_ST_RETRY]  <= retry_exhausted;
            end else begin
                if (erase_fail) begin
                    array_op_status[fpc_pkg::POS_ST_ERASE] <= 1'b1;
                end
                if (prog_done && verify_miss) begin
                    array_op_status[fpc_pkg::POS_ST_VERIFY] <= 1'b1;
                end
                if (retry_exhausted) begin
                    array_op_status[fpc_pkg::POS_ST_RETRY] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            status_read_sel <= 1'b0;
        end else if (flash_cmd_we) begin
            status_read_sel <= flash_cmd_data == fpc_pkg::CMD_READ_STATUS;
        end
    end

    // ------------------------------------------------------------------
    // Virtual flash bank selects
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            large_bank <= '0;
        end else if (wr_fire && hit_lb) begin
            if (wb_sel_i[1]) begin
                large_bank.enable <= wb_dat_i[fpc_pkg::POS_LB_EN] & emulation_mode;
            end
            if (wb_sel_i[0]) begin
                large_bank.addr <= wb_dat_i[fpc_pkg::POS_LB_ADDR_L +: 7];
            end
        end
    end

    for (genvar i = 0; i < NUM_SMALL; i++) begin : g_small
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                small_bank[i] <= '0;
            end else if (wr_fire && hit_sb[i]) begin
                if (wb_sel_i[1]) begin
                    small_bank[i].enable <= wb_dat_i[fpc_pkg::POS_SB_EN] & emulation_mode;
                end
                if (wb_sel_i[0]) begin
                    small_bank[i].addr <= wb_dat_i[fpc_pkg::POS_SB_ADDR_L +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Unassigned bits and unmapped words read zero
    always_comb begin
        next_dat = 32'h0;
        if (hit_mode) begin
            next_dat[fpc_pkg::POS_PE_MODE]  = pe_mode;
            next_dat[fpc_pkg::POS_EMU_MODE] = emulation_mode;
        end else if (hit_unlock) begin
            next_dat[fpc_pkg::POS_LOCK_OVR] = lock_override;
        end else if (hit_marg) begin
            next_dat[fpc_pkg::POS_DEEP_ERS] = deep_erase;
        end else if (hit_abort) begin
            next_dat[fpc_pkg::POS_ABORT] = flash_abort;
        end else if (hit_lb) begin
            next_dat[fpc_pkg::POS_LB_EN]        = large_bank.enable;
            next_dat[fpc_pkg::POS_LB_ADDR_L +: 7] = large_bank.addr;
        end else if (hit_sb[0] || hit_sb[1]) begin
            next_dat[fpc_pkg::POS_SB_EN]        = hit_sb[0] ? small_bank[0].enable : small_bank[1].enable;
            next_dat[fpc_pkg::POS_SB_ADDR_L +: 8] = hit_sb[0] ? small_bank[0].addr : small_bank[1].addr;
        end else if (hit_stat) begin
            next_dat[7:0] = array_op_status;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wb_dat_o <= 32'h0;
        end else if (req && !wb_we_i && !wb_ack_o) begin
            wb_dat_o <= next_dat;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    mode_set_a: assert property ($rose(pe_mode) |-> $past(wr_mode & mode_bit_wd & mode_armed & fp_lvl))
        else $error("mode entry set without two-write sequence");
    mode_fall_a: assert property (fp_fall |=> !pe_mode)
        else $error("mode entry survived protect pin fall");
    mode_only_a: assert property ((pe_mode && !fp_fall && !wr_mode) |=> pe_mode)
        else $error("mode entry dropped without cause");
    vec_addr_a: assert property (##1 ei_vector_addr == ($past(pe_mode) ? fpc_pkg::EI_VEC_RAM : fpc_pkg::EI_VEC_FLASH))
        else $error("vector address does not follow mode");
    emu_gate_a: assert property ($rose(emulation_mode) |-> $past(!pe_mode))
        else $error("emulation entered with mode entry set");
    unlock_clr_a: assert property ((!pe_mode || !fp_lvl) |=> !lock_override)
        else $error("unlock held without mode or pin");
    unlock_set_a: assert property ($rose(lock_override) |-> $past(unlock_armed & pe_mode))
        else $error("unlock set without two-write sequence");
    verify_err_a: assert property ((prog_done && verify_miss) |=> array_op_status[fpc_pkg::POS_ST_VERIFY])
        else $error("verify mismatch not flagged");
    retry_err_a: assert property (retry_exhausted |=> array_op_status[fpc_pkg::POS_ST_RETRY])
        else $error("retry exhaustion not flagged");
    abort_init_a: assert property ((flash_abort && !array_busy && !prog_done && !retry_exhausted && !erase_fail)
                                   |=> array_op_status == fpc_pkg::STATUS_INIT)
        else $error("status not reinitialised by abort");
    abort_ign_a: assert property ((wr_abort && !pe_mode) |=> !flash_abort)
        else $error("abort accepted outside mode");
    busy_flag_a: assert property (array_busy |=> !array_op_status[fpc_pkg::POS_ST_BUSY])
        else $error("busy flag not low while operating");
    bank_en_a: assert property ($rose(large_bank.enable) |-> $past(emulation_mode))
        else $error("large bank enabled outside emulation");
    stat_cmd_a: assert property ((flash_cmd_we && flash_cmd_data == fpc_pkg::CMD_READ_STATUS) |=> status_read_sel)
        else $error("read status command not taken");

    entry_c:  cover property ($rose(pe_mode));
    unlock_c: cover property ($rose(lock_override));
    abort_c:  cover property ($rose(flash_abort));

endmodule // fpc_flash_ctrl

//--- fpc_flash_model.sv
/*
 * Flash array stand-in: busy level, program and erase result pulses, commands.
 * Assumes its tasks are called from a process that follows ref_clk.
 */
module fpc_flash_model (
    input  wire logic        ref_clk,
    output logic             array_busy,
    output logic             prog_done,
    output logic [15:0]      prog_wdata,
    output logic [15:0]      prog_rdata,
    output logic             retry_exhausted,
    output logic             erase_fail,
    output logic             flash_cmd_we,
    output logic [15:0]      flash_cmd_data
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {array_busy, prog_done, retry_exhausted, erase_fail, flash_cmd_we} = 5'h00;
        prog_wdata = 16'h0000;
        prog_rdata = 16'hFFFF;
        flash_cmd_data = 16'h0000;
    end

    // --------------------------------------------------------------
    // Operations
    // --------------------------------------------------------------
    // Busy, then results
    task automatic run_op(input logic [15:0] wd, rd, input logic rx, ef, input int n);
        @(posedge ref_clk);
        array_busy <= 1'b1;
        repeat (n) @(posedge ref_clk);
        array_busy <= 1'b0;
        prog_done <= ~ef;
        prog_wdata <= wd;
        prog_rdata <= rd;
        retry_exhausted <= rx;
        erase_fail <= ef;
        @(posedge ref_clk);
        {prog_done, retry_exhausted, erase_fail} <= 3'h0;
        // Released data lines stop showing the last value
        prog_wdata <= ~wd;
        prog_rdata <= ~rd;
    endtask

    task automatic cmd(input logic [15:0] d);
        @(posedge ref_clk);
        flash_cmd_we <= 1'b1;
        flash_cmd_data <= d;
        @(posedge ref_clk);
        flash_cmd_we <= 1'b0;
        flash_cmd_data <= ~d;
    endtask
endmodule // fpc_flash_model

//--- tb_flash_program_control_regs.sv
/*
 * Self-checking bench for the flash program control registers.
 * Assumes a one-cycle Wishbone answer and the flash array model beside it.
 */
module tb_flash_program_control_regs;
    timeunit 1ns;
    timeprecision 1ns;

    logic                    ref_clk, nrst, cyc, stb, we, ack, pin;
    logic [31:0]             adr, dat, rdat, ei;
    logic [3:0]              sel;
    logic                    busy, pdone, rx, ef, cwe;
    logic [15:0]             pwd, prd, cdat;
    logic                    pe, emu, lko, deep, abrt, rsel;
    logic [7:0]              stat;
    fpc_pkg::fpc_large_bank_s lb;
    fpc_pkg::fpc_small_bank_s sb [2];
    int                      failures, n_checks, cycles;

    fpc_flash_ctrl uut (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .flash_protect_pin(pin), .array_busy(busy), .prog_done(pdone),
        .prog_wdata(pwd), .prog_rdata(prd), .retry_exhausted(rx), .erase_fail(ef),
        .flash_cmd_we(cwe), .flash_cmd_data(cdat), .pe_mode(pe), .emulation_mode(emu),
        .lock_override(lko), .deep_erase(deep), .flash_abort(abrt), .status_read_sel(rsel),
        .array_op_status(stat), .ei_vector_addr(ei), .large_bank(lb), .small_bank(sb));

    fpc_flash_model u_fm (.ref_clk(ref_clk), .array_busy(busy), .prog_done(pdone),
        .prog_wdata(pwd), .prog_rdata(prd), .retry_exhausted(rx), .erase_fail(ef),
        .flash_cmd_we(cwe), .flash_cmd_data(cdat));

    // --------------------------------------------------------------
    // Bus and check tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic [31:0] idx, input logic w, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= idx << 2;
        dat <= d;
        sel <= 4'h3;
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] idx, d);
        logic [31:0] q;
        bus(idx, 1'b1, d, q);
    endtask

    task automatic rc(input logic [31:0] idx, exp);
        logic [31:0] q;
        bus(idx, 1'b0, 32'h00000000, q);
        chk(q, exp);
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic summarize();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Clock, reset and timeout
    // --------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 5000) begin
            failures++;
            summarize();
        end
    end

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        {nrst, cyc, stb, we, pin, failures, n_checks, cycles} = '0;
        {adr, dat, sel} = '0;
        pin = 1'b1;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rc(fpc_pkg::IDX_MODE_ENTRY, 32'h00);
        rc(fpc_pkg::IDX_OP_STATUS, 32'h80);
        chk(ei, fpc_pkg::EI_VEC_FLASH);
        wr(fpc_pkg::IDX_MODE_ENTRY, 32'h10);
        rc(fpc_pkg::IDX_MODE_ENTRY, 32'h00);
        wr(fpc_pkg::IDX_MODE_ENTRY, 32'h00);
        wr(fpc_pkg::IDX_MODE_ENTRY, 32'h10);
        settle();
        chk(32'(pe), 32'h1);
        chk(ei, fpc_pkg::EI_VEC_RAM);
        wr(fpc_pkg::IDX_MODE_ENTRY, 32'h11);
        rc(fpc_pkg::IDX_MODE_ENTRY, 32'h10);
        wr(fpc_pkg::IDX_UNLOCK, 32'h01);
        rc(fpc_pkg::IDX_UNLOCK, 32'h00);
        wr(fpc_pkg::IDX_UNLOCK, 32'h00);
        wr(fpc_pkg::IDX_UNLOCK, 32'hFF);
        rc(fpc_pkg::IDX_UNLOCK, 32'h01);
        chk(32'(lko), 32'h1);
        wr(fpc_pkg::IDX_ERASE_MARG, 32'hFF);
        rc(fpc_pkg::IDX_ERASE_MARG, 32'h01);
        chk(32'(deep), 32'h1);
        fork
            u_fm.run_op(16'h0F0F, 16'h0F0F, 1'b0, 1'b0, 8);
            begin
                repeat (4) @(posedge ref_clk);
                rc(fpc_pkg::IDX_OP_STATUS, 32'h00);
            end
        join
        settle();
        rc(fpc_pkg::IDX_OP_STATUS, 32'h80);
        u_fm.run_op(16'h00F0, 16'h0070, 1'b0, 1'b0, 1);
        rc(fpc_pkg::IDX_OP_STATUS, 32'h90);
        u_fm.run_op(16'hFFFF, 16'hFFFF, 1'b1, 1'b0, 1);
        rc(fpc_pkg::IDX_OP_STATUS, 32'h98);
        u_fm.run_op(16'h0000, 16'h0000, 1'b0, 1'b1, 1);
        rc(fpc_pkg::IDX_OP_STATUS, 32'hB8);
        // Abort set and cleared only while the array is idle
        wr(fpc_pkg::IDX_ABORT, 32'h01);
        settle();
        chk(32'(abrt), 32'h1);
        rc(fpc_pkg::IDX_OP_STATUS, 32'h80);
        wr(fpc_pkg::IDX_ABORT, 32'h00);
        u_fm.cmd(fpc_pkg::CMD_READ_STATUS);
        settle();
        chk(32'(rsel), 32'h1);
        u_fm.cmd(16'hFFFF);
        settle();
        chk(32'(rsel), 32'h0);
        // Mode entry left when the protect pin falls; unlock clears with it
        pin <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk(32'(pe), 32'h0);
        chk(32'(lko), 32'h0);
        wr(fpc_pkg::IDX_ABORT, 32'h01);
        rc(fpc_pkg::IDX_ABORT, 32'h00);
        wr(fpc_pkg::IDX_MODE_ENTRY, 32'h00);
        wr(fpc_pkg::IDX_MODE_ENTRY, 32'h10);
        rc(fpc_pkg::IDX_MODE_ENTRY, 32'h00);
        wr(fpc_pkg::IDX_LARGE_BANK, 32'h80FF);
        rc(fpc_pkg::IDX_LARGE_BANK, 32'h00FE);
        wr(fpc_pkg::IDX_SMALL_BANK1, 32'h8001);
        rc(fpc_pkg::IDX_SMALL_BANK1, 32'h0001);
        wr(fpc_pkg::IDX_MODE_ENTRY, 32'h01);
        rc(fpc_pkg::IDX_MODE_ENTRY, 32'h01);
        wr(fpc_pkg::IDX_LARGE_BANK, 32'hFFFF);
        rc(fpc_pkg::IDX_LARGE_BANK, 32'h80FE);
        chk(32'(lb), 32'hFF);
        wr(fpc_pkg::IDX_SMALL_BANK0, 32'hFFA5);
        rc(fpc_pkg::IDX_SMALL_BANK0, 32'h80A5);
        chk(32'(sb[0]), 32'h1A5);
        wr(fpc_pkg::IDX_SMALL_BANK1, 32'h8001);
        rc(fpc_pkg::IDX_SMALL_BANK1, 32'h8001);
        rc(32'h00000000, 32'h00);
        summarize();
    end
endmodule // tb_flash_program_control_regs
